// >>> logic/mtt_pkg.sv
// constants for the ten-bit match timer: register map, fields, reset values
`default_nettype none

package mtt_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 10;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] IDX_CTRL_STATUS = 8'hb0;
    localparam logic [7:0] IDX_CLOCK_PRIO  = 8'hb1;
    localparam logic [7:0] IDX_CMP1_HIGH   = 8'hb2;
    localparam logic [7:0] IDX_CMP1_LOW    = 8'hb3;
    localparam logic [7:0] IDX_CMP2_HIGH   = 8'hb4;
    localparam logic [7:0] IDX_CMP2_LOW    = 8'hb5;
    localparam logic [7:0] IDX_COUNT_HIGH  = 8'hbe;
    localparam logic [7:0] IDX_COUNT_LOW   = 8'hbf;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CSR_RUN_BIT   = 0;
    localparam int CSR_FLAG_LSB  = 1;
    localparam int CTRL_PRIO_LSB = 0;
    localparam int CTRL_SEL_LSB  = 2;
    localparam int HIGH_LSB      = 6;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] SEL_DIV2     = 2'h0;
    localparam logic [1:0] SEL_EXT      = 2'h1;
    localparam logic [1:0] PRIO_OFF     = 2'h0;
    localparam logic [3:0] PRE_LAST     = 4'hf;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic       RST_RUN      = 1'h0;
    localparam logic [1:0] RST_IRQ_EN   = 2'h0;
    localparam logic [1:0] RST_CLK_SEL  = 2'h0;
    localparam logic [1:0] RST_PRIO     = 2'h0;
    localparam logic [9:0] RST_COMPARE  = 10'h000;
    localparam logic [9:0] RST_COUNT    = 10'h000;

endpackage

`default_nettype wire

// >>> logic/mtt_compare_slot.sv
// one comparator: buffered compare value, active value, match detect
`default_nettype none

module mtt_compare_slot
    import mtt_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // software loads
    input  wire logic             load_low,
    input  wire logic             load_high,
    input  wire logic [7:0]       wr_byte,
    // counter side
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] next_count,
    output logic                  hit
);

    typedef struct packed {
        logic [CNT_W-1:0] active;
        logic [CNT_W-1:0] buffer;
    } mtt_slot_t;

    mtt_slot_t state;
    mtt_slot_t next_state;

    // ****************************************
    // match only when the counter steps onto the value, not while it idles there
    // ****************************************
    assign hit = tick && (next_count == state.active);

    always_comb begin
        next_state = state;
        if (load_low) begin
            next_state.buffer[7:0] = wr_byte;
        end
        if (load_high) begin
            next_state.buffer[9:8] = wr_byte[7:HIGH_LSB];
        end
        if (hit) begin
            next_state.active = state.buffer;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state.active <= RST_COMPARE;
            state.buffer <= RST_COMPARE;
        end else begin
            state <= next_state;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_buffer_load: assert property (hit |=> state.active == $past(state.buffer))
        else $error("active compare not loaded from buffer on match");
    chk_active_hold: assert property (!hit |=> $stable(state.active))
        else $error("active compare changed without a match");

endmodule

`default_nettype wire

// >>> logic/mtt_top.sv
// ten-bit match timer with two comparators behind an axi4-lite slave
//
// Local design decision: the AXI4-Lite register port.
`default_nettype none

// Operation
// - one free-running ten-bit up-counter, two independent comparators
// - clock select bits 3:2: 00 div2, 01 external tick, 1x div16
// - counter reaching active value pulses output and sets that flag
// - written compare is buffered, moves to active only on a match
// - compare high takes bits 9:8 from written 7:6, rest reads zero
// - status read bits 2:1 show comparators matched since last read
// - status read clears both flags and pending request, keeps enables
// - status write bits 2:1 enable interrupt per comparator
// - status write bit 0 gates the counter clock
// - status bits 7:3 always read zero
// - priority bits 1:0: 00 blocks requests, else level one to three
// - match pulse offered as strobe for parallel port output timing
// - match pulse stays internal, never driven onto a pin
// - compare low register stores eight low bits of next compare
// - count high gives bits 9:8 in 7:6, count low bits 7:0
module mtt_top
    import mtt_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // external countdown source, one-cycle pulse per underflow
    input  wire logic              ext_count_tick,
    // internal strobes and interrupt request
    output logic [1:0]             match_strobe,
    output logic                   irq_request,
    output logic [1:0]             irq_priority
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [CNT_W-1:0]  cnt;
        logic [3:0]        pre;
        logic              run;
        logic [1:0]        irq_en;
        logic [1:0]        flags;
        logic              irq_pend;
        logic [1:0]        clk_sel;
        logic [1:0]        prio;
        logic [1:0]        strobe;
        logic              irq_req;
        logic [1:0]        irq_lvl;
        logic              awready;
        logic              aw_full;
        logic [ADDR_W-1:0] awaddr;
        logic              wready;
        logic              w_full;
        logic [7:0]        wdata;
        logic              wbyte;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
    } mtt_state_t;

    mtt_state_t state;
    mtt_state_t next_state;

    // ****************************************
    // address decode
    // ****************************************
    // returns {mapped, index}; misaligned or out-of-window addresses are unmapped
    function automatic logic [8:0] decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        logic       ok;
        idx = addr[9:2];
        ok  = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0);
        case (idx)
            IDX_CTRL_STATUS, IDX_CLOCK_PRIO, IDX_CMP1_HIGH, IDX_CMP1_LOW,
            IDX_CMP2_HIGH, IDX_CMP2_LOW, IDX_COUNT_HIGH, IDX_COUNT_LOW: begin
                decode = {ok, idx};
            end
            default: begin
                decode = {1'b0, idx};
            end
        endcase
    endfunction

    logic [8:0] wr_dec;
    logic [8:0] rd_dec;
    logic       do_wr;
    logic       wr_ok;
    logic       aw_take;
    logic       w_take;
    logic       ar_take;
    logic       csr_read;

    assign wr_dec   = decode(state.awaddr);
    assign rd_dec   = decode(s_axi_araddr);
    assign aw_take  = s_axi_awvalid && state.awready;
    assign w_take   = s_axi_wvalid && state.wready;
    assign ar_take  = s_axi_arvalid && state.arready;
    assign do_wr    = state.aw_full && state.w_full && !state.bvalid;
    // a write without byte lane 0 is answered but changes nothing
    assign wr_ok    = do_wr && wr_dec[8] && state.wbyte;
    assign csr_read = ar_take && rd_dec[8] && (rd_dec[7:0] == IDX_CTRL_STATUS);

    // ****************************************
    // counter clocking
    // ****************************************
    logic             tick;
    logic             src_tick;
    logic [CNT_W-1:0] next_count;
    logic [1:0]       hit;

    always_comb begin
        case (state.clk_sel)
            SEL_DIV2: begin
                src_tick = state.pre[0];
            end
            SEL_EXT: begin
                src_tick = ext_count_tick;
            end
            default: begin
                src_tick = (state.pre == PRE_LAST);
            end
        endcase
    end

    assign tick       = state.run && src_tick;
    assign next_count = state.cnt + 10'h001;

    // ****************************************
    // comparators
    // ****************************************
    mtt_compare_slot u_slot1 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .load_low   (wr_ok && (wr_dec[7:0] == IDX_CMP1_LOW)),
        .load_high  (wr_ok && (wr_dec[7:0] == IDX_CMP1_HIGH)),
        .wr_byte    (state.wdata),
        .tick       (tick),
        .next_count (next_count),
        .hit        (hit[0])
    );

    mtt_compare_slot u_slot2 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .load_low   (wr_ok && (wr_dec[7:0] == IDX_CMP2_LOW)),
        .load_high  (wr_ok && (wr_dec[7:0] == IDX_CMP2_HIGH)),
        .wr_byte    (state.wdata),
        .tick       (tick),
        .next_count (next_count),
        .hit        (hit[1])
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_state = state;

        // prescaler runs from the peripheral clock regardless of the gate
        next_state.pre = state.pre + 4'h1;
        if (tick) begin
            next_state.cnt = next_count;
        end

        // a match in the same cycle as the clearing read survives
        next_state.flags  = (csr_read ? 2'h0 : state.flags) | hit;
        next_state.irq_pend = (csr_read ? 1'b0 : state.irq_pend) | |(hit & state.irq_en);
        next_state.strobe = hit;
        next_state.irq_req = next_state.irq_pend && (state.prio != PRIO_OFF);
        next_state.irq_lvl = state.prio;

        // write address and data, in either order
        if (aw_take) begin
            next_state.aw_full = 1'b1;
            next_state.awready = 1'b0;
            next_state.awaddr  = s_axi_awaddr;
        end
        if (w_take) begin
            next_state.w_full = 1'b1;
            next_state.wready = 1'b0;
            next_state.wdata  = s_axi_wdata[7:0];
            next_state.wbyte  = s_axi_wstrb[0];
        end
        if (do_wr) begin
            next_state.aw_full = 1'b0;
            next_state.w_full  = 1'b0;
            next_state.awready = 1'b1;
            next_state.wready  = 1'b1;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = wr_dec[8] ? RESP_OKAY : RESP_SLVERR;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        if (wr_ok && (wr_dec[7:0] == IDX_CTRL_STATUS)) begin
            next_state.run    = state.wdata[CSR_RUN_BIT];
            next_state.irq_en = state.wdata[CSR_FLAG_LSB +: 2];
        end
        if (wr_ok && (wr_dec[7:0] == IDX_CLOCK_PRIO)) begin
            next_state.clk_sel = state.wdata[CTRL_SEL_LSB +: 2];
            next_state.prio    = state.wdata[CTRL_PRIO_LSB +: 2];
        end

        // read path, data captured at the address handshake
        if (ar_take) begin
            next_state.arready = 1'b0;
            next_state.rvalid  = 1'b1;
            next_state.rresp   = rd_dec[8] ? RESP_OKAY : RESP_SLVERR;
            case (rd_dec[7:0])
                IDX_CTRL_STATUS: begin
                    next_state.rdata = {5'h00, state.flags, 1'b0};
                end
                IDX_COUNT_HIGH: begin
                    next_state.rdata = {state.cnt[9:8], 6'h00};
                end
                IDX_COUNT_LOW: begin
                    next_state.rdata = state.cnt[7:0];
                end
                default: begin
                    // write-only registers read as zero
                    next_state.rdata = 8'h00;
                end
            endcase
            if (!rd_dec[8]) begin
                next_state.rdata = 8'h00;
            end
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid  = 1'b0;
            next_state.arready = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state         <= '0;
            state.cnt     <= RST_COUNT;
            state.run     <= RST_RUN;
            state.irq_en  <= RST_IRQ_EN;
            state.clk_sel <= RST_CLK_SEL;
            state.prio    <= RST_PRIO;
            state.awready <= 1'b1;
            state.wready  <= 1'b1;
            state.arready <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = state.awready;
    assign s_axi_wready  = state.wready;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rresp   = state.rresp;
    assign s_axi_rdata   = {24'h000000, state.rdata};
    assign match_strobe  = state.strobe;
    assign irq_request   = state.irq_req;
    assign irq_priority  = state.irq_lvl;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_count_step: assert property (tick |=> state.cnt == $past(next_count))
        else $error("counter did not advance by one on tick");
    chk_count_wrap: assert property ((tick && state.cnt == 10'h3ff) |=> state.cnt == 10'h000)
        else $error("counter did not wrap to zero");
    chk_clock_gate: assert property (!state.run |=> $stable(state.cnt))
        else $error("counter moved while its clock was gated");
    chk_div16_gap: assert property ((state.run && state.clk_sel[1] && state.pre != PRE_LAST)
                                    |-> !tick)
        else $error("div16 tick outside prescaler terminal count");
    chk_div2_rate: assert property ((state.run && state.clk_sel == SEL_DIV2) |=>
                                    !state.run || state.clk_sel != SEL_DIV2 || tick != $past(tick))
        else $error("div2 tick not alternating");
    chk_match_flag: assert property (hit[0] |=> state.flags[0] && match_strobe[0])
        else $error("match did not set flag and strobe");
    chk_read_clear: assert property ((csr_read && hit == 2'h0) |=>
                                     state.flags == 2'h0 && !state.irq_pend
                                     && $stable(state.irq_en))
        else $error("status read did not clear flags and request");
    chk_status_zero: assert property (csr_read |=> s_axi_rvalid && s_axi_rdata[31:3] == '0
                                      && s_axi_rdata[0] == 1'b0)
        else $error("status upper bits not zero");
    chk_prio_block: assert property ((state.prio == PRIO_OFF) |=> !irq_request)
        else $error("request raised with priority off");
    chk_irq_level: assert property (irq_request |-> irq_priority != PRIO_OFF
                                    && irq_priority == $past(state.prio))
        else $error("request level does not match priority");
    chk_irq_enable: assert property ((hit[1] && state.irq_en[1] && state.prio != PRIO_OFF)
                                     |=> irq_request)
        else $error("enabled match did not request");

endmodule

`default_nettype wire

// >>> dv/mtt_top_tb.sv
// self-checking bench for the ten-bit match timer
`default_nettype none

module mtt_top_tb import mtt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // signals
    // ****************************************
    logic              ref_clk = 1'b0;
    logic              rst     = 1'b1;
    logic [ADDR_W-1:0] awaddr  = '0;
    logic              awvalid = 1'b0;
    logic              awready;
    logic [DATA_W-1:0] wdata   = '0;
    logic              wvalid  = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready  = 1'b0;
    logic [ADDR_W-1:0] araddr  = '0;
    logic              arvalid = 1'b0;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready  = 1'b0;
    logic              ext_count_tick = 1'b0;
    logic [1:0]        match_strobe;
    logic              irq_request;
    logic [1:0]        irq_priority;
    int                fail_count  = 0;
    int                checks_done = 0;
    // reference model of counter and comparators
    int                cnt_m = 0;
    logic [9:0]        act_m[2] = '{10'h000, 10'h000};
    logic [9:0]        buf_m[2] = '{10'h000, 10'h000};
    logic              run_m = 1'b0;

    always #2.5 ref_clk = ~ref_clk;

    mtt_top i_dut (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_count_tick(ext_count_tick),
        .match_strobe(match_strobe), .irq_request(irq_request),
        .irq_priority(irq_priority)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // byte address is four times the register index
    task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er);
        int n;
        n = 0;
        awaddr  <= ADDR_W'({idx, 2'b00});
        wdata   <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (n < 100) begin
            @(posedge ref_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                check({30'h0, bresp}, {30'h0, er});
                break;
            end
        end
        check(32'(n < 100), 32'h1);
    endtask

    // bits set in dc are not compared, for values the bench cannot predict
    task automatic rdx(input logic [7:0] idx, input logic [31:0] ed, input logic [31:0] dc,
                       input logic [1:0] er, output logic [31:0] d);
        int n;
        n = 0;
        d = '0;
        araddr  <= ADDR_W'({idx, 2'b00});
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (n < 100) begin
            @(posedge ref_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                check({30'h0, rresp}, {30'h0, er});
                break;
            end
        end
        check(32'(n < 100), 32'h1);
        check(d & ~dc, ed);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] ed);
        logic [31:0] d;
        rdx(idx, ed, 32'h0, RESP_OKAY, d);
    endtask

    task automatic wr_cmp(input int i, input logic [9:0] v);
        // low byte first, junk in the unused high bits must be dropped
        wr(i ? IDX_CMP2_LOW : IDX_CMP1_LOW, v[7:0], RESP_OKAY);
        wr(i ? IDX_CMP2_HIGH : IDX_CMP1_HIGH, {v[9:8], 6'h3f}, RESP_OKAY);
        buf_m[i] = v;
    endtask

    task automatic tick(input int n);
        logic [1:0] hit;
        for (int k = 0; k < n; k++) begin
            hit  = 2'b00;
            ext_count_tick <= 1'b1;
            @(posedge ref_clk);
            ext_count_tick <= 1'b0;
            if (run_m) begin
                cnt_m = (cnt_m + 1) % 1024;
                for (int i = 0; i < 2; i++) begin
                    if (cnt_m == int'(act_m[i])) begin
                        hit[i]   = 1'b1;
                        act_m[i] = buf_m[i];
                    end
                end
            end
            // registered strobe stands only in the cycle after the tick edge
            @(posedge ref_clk);
            check({30'h0, match_strobe}, {30'h0, hit});
            @(posedge ref_clk);
            check({30'h0, match_strobe}, 32'h0);
            @(posedge ref_clk);
        end
    endtask

    // a negative expected count means the count bits are not predicted
    task automatic rd_cnt(input int e, output int c);
        logic [31:0] h;
        logic [31:0] l;
        logic [31:0] dc;
        logic [9:0]  v;
        v  = 10'(e);
        dc = (e < 0) ? 32'hc0 : 32'h0;
        rdx(IDX_COUNT_HIGH, {24'h0, v[9:8], 6'h0} & ~dc, dc, RESP_OKAY, h);
        check({26'h0, h[5:0]}, 32'h0);
        dc = (e < 0) ? 32'hff : 32'h0;
        rdx(IDX_COUNT_LOW, {24'h0, v[7:0]} & ~dc, dc, RESP_OKAY, l);
        c = int'({h[7:6], l[7:0]});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] d;
        rd(IDX_CTRL_STATUS, 32'h0);
        rd(IDX_CMP1_HIGH, 32'h0);
        rd(IDX_COUNT_HIGH, 32'h0);
        rdx(8'h10, 32'h0, 32'h0, RESP_SLVERR, d);
        wr(8'h10, 8'hff, RESP_SLVERR);
        wr(IDX_COUNT_LOW, 8'h55, RESP_OKAY);
        rd(IDX_COUNT_LOW, 32'h0);
        check({31'h0, irq_request}, 32'h0);
    endtask

    task automatic t_wrap();
        int c;
        // source picked before the gate opens, else div2 moves the counter
        wr(IDX_CLOCK_PRIO, {4'h0, SEL_EXT, PRIO_OFF}, RESP_OKAY);
        wr(IDX_CTRL_STATUS, 8'h07, RESP_OKAY);
        run_m = 1'b1;
        wr_cmp(0, 10'h105);
        wr_cmp(1, 10'h010);
        // priority last, it opens the request at once
        wr(IDX_CLOCK_PRIO, {4'h0, SEL_EXT, 2'h1}, RESP_OKAY);
        tick(1024);
        rd_cnt(0, c);
        check(32'(c), 32'h0);
        check({31'h0, irq_request}, 32'h1);
        check({30'h0, irq_priority}, 32'h1);
        rd(IDX_CTRL_STATUS, 32'h6);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq_request}, 32'h0);
        rd(IDX_CTRL_STATUS, 32'h0);
    endtask

    task automatic t_enable();
        int c;
        wr(IDX_CTRL_STATUS, 8'h03, RESP_OKAY);
        wr_cmp(0, 10'h120);
        tick(16);
        check({31'h0, irq_request}, 32'h0);
        rd(IDX_CTRL_STATUS, 32'h4);
        tick(10'h105 - 10'h010);
        check({31'h0, irq_request}, 32'h1);
        for (int p = 0; p < 4; p++) begin
            wr(IDX_CLOCK_PRIO, {4'h0, SEL_EXT, 2'(p)}, RESP_OKAY);
            repeat (2) @(posedge ref_clk);
            check({30'h0, irq_priority}, 32'(p));
            check({31'h0, irq_request}, 32'(p != 0));
        end
        rd(IDX_CTRL_STATUS, 32'h2);
        tick(10'h120 - 10'h105);
        rd_cnt(cnt_m, c);
        check(32'(c), 32'(cnt_m));
    endtask

    task automatic t_gate();
        int c;
        wr(IDX_CTRL_STATUS, 8'h06, RESP_OKAY);
        run_m = 1'b0;
        tick(4);
        rd_cnt(cnt_m, c);
        check(32'(c), 32'(cnt_m));
    endtask

    task automatic t_select();
        int c0;
        int c1;
        int d;
        logic [1:0] sel[3] = '{SEL_DIV2, 2'h2, 2'h3};
        // the gate is open for 203 edges: 101 or 102 ticks at div2, 12 or 13 at div16
        int lo[3] = '{101, 12, 12};
        int hi[3] = '{102, 13, 13};
        for (int s = 0; s < 3; s++) begin
            wr(IDX_CTRL_STATUS, 8'h00, RESP_OKAY);
            wr(IDX_CLOCK_PRIO, {4'h0, sel[s], 2'h0}, RESP_OKAY);
            rd_cnt(-1, c0);
            wr(IDX_CTRL_STATUS, 8'h01, RESP_OKAY);
            repeat (200) @(posedge ref_clk);
            wr(IDX_CTRL_STATUS, 8'h00, RESP_OKAY);
            rd_cnt(-1, c1);
            d = (c1 - c0 + 1024) % 1024;
            check(32'(d >= lo[s] && d <= hi[s]), 32'h1);
        end
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_wrap();
        t_enable();
        t_gate();
        t_select();
        end_sim();
    end

    // runs take about 6000 cycles, so this limit leaves ample slack
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        end_sim();
    end
endmodule

`default_nettype wire
